// >>> include/dpio_defs.svh
`ifndef DPIO_DEFS_SVH
`define DPIO_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define DPIO_IDX_FIRST 8'h08
`define DPIO_IDX_SECOND 8'h09
`define DPIO_IDX_THIRD 8'h0a
`define DPIO_IDX_CFG 8'h0b

// ==========================================================
// Configuration byte bit positions
// ==========================================================
`define DPIO_CFG_C_LOW 0
`define DPIO_CFG_SECOND 1
`define DPIO_CFG_UNUSED 2
`define DPIO_CFG_C_HIGH 3
`define DPIO_CFG_FIRST 4
`define DPIO_CFG_SIM 5
`define DPIO_CFG_WIDE 6
`define DPIO_CFG_CTR_SEL 7

// ==========================================================
// Reset values and masks
// ==========================================================
`define DPIO_CFG_RESET 8'h1b
`define DPIO_CFG_WMASK 8'hfb
`define DPIO_DATA_RESET 8'h00
`define DPIO_CTR_PIN_OE 4'h8
`define DPIO_HTRANS_ACTIVE 1
`define DPIO_HRESP_OKAY 1'h0

`endif

// >>> include/dpio_pkg.sv
package dpio_pkg;

  // Field order matches the configuration byte, bit 7 first
  typedef struct packed {
    logic counter_pin_select;
    logic converter_wide_mode;
    logic converter_simultaneous_update;
    logic first_port_direction;
    logic third_port_upper_direction;
    logic unused;
    logic second_port_direction;
    logic third_port_lower_direction;
  } dpio_cfg_s;

  // Pin drive of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dpio_pin_s;

  // Register selected by the latched address phase
  typedef enum logic [4:0] {
    DPIO_SEL_NONE = 5'b00001,
    DPIO_SEL_FIRST = 5'b00010,
    DPIO_SEL_SECOND = 5'b00100,
    DPIO_SEL_THIRD = 5'b01000,
    DPIO_SEL_CFG = 5'b10000
  } dpio_sel_e;

endpackage : dpio_pkg

// >>> logic/dpio_top.sv
`timescale 1ns/1ns
`include "dpio_defs.svh"

// ==========================================================
// ==========================================================
module dpio_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // First port pins
  input wire logic [7:0] first_port_bits_in,
  output logic [7:0] first_port_bits_out,
  output logic [7:0] first_port_bits_oe,
  // Second port pins
  input wire logic [7:0] second_port_bits_in,
  output logic [7:0] second_port_bits_out,
  output logic [7:0] second_port_bits_oe,
  // Third port pins
  input wire logic [7:0] third_port_bits_in,
  output logic [7:0] third_port_bits_out,
  output logic [7:0] third_port_bits_oe,
  // Counter/timer side
  input wire logic ctr0_out_in,
  output logic ctr0_gate,
  output logic ctr1_gate,
  output logic ctr1_clk,
  // Converter controls and counter select
  output logic converter_wide_mode,
  output logic converter_simultaneous_update,
  output logic counter_pin_select
);

  // ========================================================
  // Elaboration check
  // ========================================================
  if (ADDR_W < 6) begin : g_bad_addr
    $error("dpio_top: ADDR_W must be at least 6");
  end

  // ========================================================
  // Address phase decode
  // ========================================================
  logic addr_take;
  logic aligned;
  logic [ADDR_W-3:0] widx;
  dpio_pkg::dpio_sel_e sel_ap;
  assign addr_take = hsel & htrans[`DPIO_HTRANS_ACTIVE] & hready;
  assign aligned = (haddr[1:0] == 2'h0);
  assign widx = haddr[ADDR_W-1:2];
  assign sel_ap = !aligned ? dpio_pkg::DPIO_SEL_NONE :
    (widx == (ADDR_W-2)'(`DPIO_IDX_FIRST)) ? dpio_pkg::DPIO_SEL_FIRST :
    (widx == (ADDR_W-2)'(`DPIO_IDX_SECOND)) ? dpio_pkg::DPIO_SEL_SECOND :
    (widx == (ADDR_W-2)'(`DPIO_IDX_THIRD)) ? dpio_pkg::DPIO_SEL_THIRD :
    (widx == (ADDR_W-2)'(`DPIO_IDX_CFG)) ? dpio_pkg::DPIO_SEL_CFG :
    dpio_pkg::DPIO_SEL_NONE;

  // Latched write target for the data phase
  dpio_pkg::dpio_sel_e wsel_q;
  dpio_pkg::dpio_sel_e wsel_d;
  assign wsel_d = (addr_take && hwrite) ? sel_ap : dpio_pkg::DPIO_SEL_NONE;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wsel_q <= dpio_pkg::DPIO_SEL_NONE;
    end else begin
      wsel_q <= wsel_d;
    end
  end

  // ========================================================
  // Registers
  // ========================================================
  logic [7:0] first_q;
  logic [7:0] first_d;
  logic [7:0] second_q;
  logic [7:0] second_d;
  logic [7:0] third_q;
  logic [7:0] third_d;
  dpio_pkg::dpio_cfg_s cfg_q;
  dpio_pkg::dpio_cfg_s cfg_d;

  // Data registers store even in input mode, so a later switch to
  // output drives the value software last wrote
  assign first_d = (wsel_q == dpio_pkg::DPIO_SEL_FIRST) ? hwdata[7:0] : first_q;
  assign second_d = (wsel_q == dpio_pkg::DPIO_SEL_SECOND) ? hwdata[7:0] : second_q;
  assign third_d = (wsel_q == dpio_pkg::DPIO_SEL_THIRD) ? hwdata[7:0] : third_q;
  // Converter bits are written along with directions; unused bit 2 is masked to zero
  assign cfg_d = (wsel_q == dpio_pkg::DPIO_SEL_CFG) ?
    dpio_pkg::dpio_cfg_s'(hwdata[7:0] & `DPIO_CFG_WMASK) : cfg_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_q <= `DPIO_DATA_RESET;
      second_q <= `DPIO_DATA_RESET;
      third_q <= `DPIO_DATA_RESET;
      cfg_q <= dpio_pkg::dpio_cfg_s'(`DPIO_CFG_RESET);
    end else begin
      first_q <= first_d;
      second_q <= second_d;
      third_q <= third_d;
      cfg_q <= cfg_d;
    end
  end

  // ========================================================
  // Direction masks (1 = input), from next register state
  // ========================================================
  logic [7:0] first_in_m;
  logic [7:0] second_in_m;
  logic [3:0] third_lo_in_m;
  logic [3:0] third_hi_in_m;
  logic [7:0] third_in_m;
  logic [7:0] third_src;
  assign first_in_m = {8{cfg_d.first_port_direction}};
  assign second_in_m = {8{cfg_d.second_port_direction}};
  assign third_lo_in_m = {4{cfg_d.third_port_lower_direction}};
  // Counter mode fixes the upper pins whatever the direction bit says
  assign third_hi_in_m = cfg_d.counter_pin_select ? ~`DPIO_CTR_PIN_OE :
    {4{cfg_d.third_port_upper_direction}};
  assign third_in_m = {third_hi_in_m, third_lo_in_m};
  // In counter mode bit 7 carries the counter 0 output
  assign third_src = cfg_d.counter_pin_select ?
    {ctr0_out_in, third_d[6:0]} : third_d;

  // ========================================================
  // Read mux (uses next state so a read right after a write sees it)
  // ========================================================
  logic [7:0] first_rd;
  logic [7:0] second_rd;
  logic [7:0] third_rd;
  logic [7:0] rd_byte;
  logic rd_take;
  assign first_rd = (first_in_m & first_port_bits_in) | (~first_in_m & first_d);
  assign second_rd = (second_in_m & second_port_bits_in) | (~second_in_m & second_d);
  assign third_rd = (third_in_m & third_port_bits_in) | (~third_in_m & third_src);
  assign rd_take = addr_take & ~hwrite;
  assign rd_byte = (sel_ap == dpio_pkg::DPIO_SEL_FIRST) ? first_rd :
    (sel_ap == dpio_pkg::DPIO_SEL_SECOND) ? second_rd :
    (sel_ap == dpio_pkg::DPIO_SEL_THIRD) ? third_rd :
    (sel_ap == dpio_pkg::DPIO_SEL_CFG) ? cfg_d : 8'h00;

  // ========================================================
  // Bus response: zero wait states, always OKAY
  // ========================================================
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'h1;
      hresp_q <= `DPIO_HRESP_OKAY;
    end else begin
      hrdata_q <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout_q <= 1'h1;
      hresp_q <= `DPIO_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ========================================================
  // Pin drivers (registered, loaded from next state on the same edge as the registers)
  // ========================================================
  dpio_pkg::dpio_pin_s first_pin_q;
  dpio_pkg::dpio_pin_s second_pin_q;
  dpio_pkg::dpio_pin_s third_pin_q;
  logic ctr0_gate_q;
  logic ctr1_gate_q;
  logic ctr1_clk_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_pin_q <= '0;
      second_pin_q <= '0;
      third_pin_q <= '0;
    end else begin
      first_pin_q <= '{out: first_d, oe: ~first_in_m};
      second_pin_q <= '{out: second_d, oe: ~second_in_m};
      third_pin_q <= '{out: third_src, oe: ~third_in_m};
    end
  end

  // Gate and clock feeds stay low outside counter mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctr0_gate_q <= 1'h0;
      ctr1_gate_q <= 1'h0;
      ctr1_clk_q <= 1'h0;
    end else begin
      ctr0_gate_q <= cfg_q.counter_pin_select & third_port_bits_in[4];
      ctr1_gate_q <= cfg_q.counter_pin_select & third_port_bits_in[5];
      ctr1_clk_q <= cfg_q.counter_pin_select & third_port_bits_in[6];
    end
  end

  assign first_port_bits_out = first_pin_q.out;
  assign first_port_bits_oe = first_pin_q.oe;
  assign second_port_bits_out = second_pin_q.out;
  assign second_port_bits_oe = second_pin_q.oe;
  assign third_port_bits_out = third_pin_q.out;
  assign third_port_bits_oe = third_pin_q.oe;
  assign ctr0_gate = ctr0_gate_q;
  assign ctr1_gate = ctr1_gate_q;
  assign ctr1_clk = ctr1_clk_q;
  assign converter_wide_mode = cfg_q.converter_wide_mode;
  assign converter_simultaneous_update = cfg_q.converter_simultaneous_update;
  assign counter_pin_select = cfg_q.counter_pin_select;

  // ========================================================
  // Assertions
  // ========================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_reset_no_drive: assert property (
    $fell(srst) |-> (first_port_bits_oe == 8'h00) && (second_port_bits_oe == 8'h00)
      && (third_port_bits_oe == 8'h00) && (cfg_q == `DPIO_CFG_RESET))
    else $error("Port driven or config wrong after reset");

  a_first_dir: assert property (
    ##1 first_port_bits_oe == {8{~cfg_q.first_port_direction}})
    else $error("First port enable does not follow bit 4");

  a_second_dir: assert property (
    ##1 second_port_bits_oe == {8{~cfg_q.second_port_direction}})
    else $error("Second port enable does not follow bit 1");

  a_third_low_dir: assert property (
    ##1 third_port_bits_oe[3:0] == {4{~cfg_q.third_port_lower_direction}})
    else $error("Third port low nibble enable does not follow bit 0");

  a_third_high_dir: assert property (
    ##1 !cfg_q.counter_pin_select |->
      third_port_bits_oe[7:4] == {4{~cfg_q.third_port_upper_direction}})
    else $error("Third port high nibble enable does not follow bit 3");

  a_ctr_pin_use: assert property (
    ##1 cfg_q.counter_pin_select |->
      (third_port_bits_oe[7:4] == `DPIO_CTR_PIN_OE)
      && (third_port_bits_out[7] == $past(ctr0_out_in)))
    else $error("Counter pin usage wrong");

  a_ctr_ignores_dir: assert property (
    ##1 cfg_q.counter_pin_select && $stable(cfg_q.counter_pin_select)
      && $changed(cfg_q.third_port_upper_direction) |-> $stable(third_port_bits_oe[7:4]))
    else $error("Upper direction bit acted in counter mode");

  a_gate_follow: assert property (
    cfg_q.counter_pin_select |=> ctr0_gate == $past(third_port_bits_in[4])
      && ctr1_gate == $past(third_port_bits_in[5])
      && ctr1_clk == $past(third_port_bits_in[6]))
    else $error("Counter inputs not passed through");

  a_upper_io: assert property (
    ##1 !cfg_q.counter_pin_select |-> third_port_bits_out[7:4] == third_q[7:4])
    else $error("Upper nibble not ordinary output");

  a_write_first: assert property (
    addr_take && hwrite && (sel_ap == dpio_pkg::DPIO_SEL_FIRST)
      |=> ##1 first_q == $past(hwdata[7:0]))
    else $error("First port write lost");

  a_cfg_write: assert property (
    wsel_q == dpio_pkg::DPIO_SEL_CFG |=> cfg_q == ($past(hwdata[7:0]) & `DPIO_CFG_WMASK))
    else $error("Config write wrong");

  a_unused_zero: assert property (
    cfg_q.unused == 1'h0)
    else $error("Unused config bit set");

  a_conv_keep: assert property (
    wsel_q != dpio_pkg::DPIO_SEL_CFG |=> $stable(cfg_q[6:5]))
    else $error("Converter bits changed without config write");

  a_read_input: assert property (
    rd_take && (sel_ap == dpio_pkg::DPIO_SEL_SECOND) && cfg_d.second_port_direction
      |=> hrdata[7:0] == $past(second_port_bits_in))
    else $error("Input read not pin level");

  a_read_output: assert property (
    rd_take && (sel_ap == dpio_pkg::DPIO_SEL_FIRST) && !cfg_d.first_port_direction
      |=> hrdata[7:0] == first_q)
    else $error("Output read not written value");

  a_bus_okay: assert property (
    hreadyout && (hresp == `DPIO_HRESP_OKAY) && (hrdata[31:8] == 24'h00_0000))
    else $error("Bus answer not ready OKAY");

  a_gate_idle: assert property (
    !cfg_q.counter_pin_select |=> !ctr0_gate && !ctr1_gate && !ctr1_clk)
    else $error("Counter feeds active outside counter mode");

  a_unmapped_zero: assert property (
    rd_take && (sel_ap == dpio_pkg::DPIO_SEL_NONE) |=> hrdata == 32'h0000_0000)
    else $error("Unmapped read not zero");

  c_ctr_mode: cover property (
    wsel_q == dpio_pkg::DPIO_SEL_CFG && hwdata[`DPIO_CFG_CTR_SEL] ##1 cfg_q.counter_pin_select);

  c_drive_first: cover property (
    !cfg_q.first_port_direction ##1 first_port_bits_oe == 8'hff);

  c_read_third: cover property (
    rd_take && (sel_ap == dpio_pkg::DPIO_SEL_THIRD));

  c_write_read: cover property (
    wsel_q == dpio_pkg::DPIO_SEL_SECOND && rd_take && sel_ap == dpio_pkg::DPIO_SEL_SECOND);

endmodule : dpio_top

// >>> verif/dpio_pin_model.sv
`timescale 1ns/1ns
// ==========================================================
// External equipment on the connector lines
// ==========================================================
module dpio_pin_model (
  // Device drive of each port
  input wire dpio_pkg::dpio_pin_s first_drv,
  input wire dpio_pkg::dpio_pin_s second_drv,
  input wire dpio_pkg::dpio_pin_s third_drv,
  // Levels the equipment forces on lines the device leaves free
  input wire logic [23:0] ext_level,
  // Wire levels seen back by the device
  output logic [7:0] first_lvl,
  output logic [7:0] second_lvl,
  output logic [7:0] third_lvl
);
  // A driven bit follows the device, a free bit follows the equipment
  assign first_lvl = (first_drv.out & first_drv.oe) | (ext_level[7:0] & ~first_drv.oe);
  assign second_lvl = (second_drv.out & second_drv.oe) | (ext_level[15:8] & ~second_drv.oe);
  assign third_lvl = (third_drv.out & third_drv.oe) | (ext_level[23:16] & ~third_drv.oe);
endmodule : dpio_pin_model

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, ctr0_gate, ctr1_gate, ctr1_clk;
  logic ctr0_out_in = 1'b0;
  logic conv_wide, conv_sim, ctr_sel;
  logic [31:0] hrdata;
  logic [23:0] ext_level = 24'h0;
  wire [7:0] lvl [3];
  wire [7:0] out_w [3];
  wire [7:0] oe_w [3];
  integer seed = 1;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;

  dpio_top dpio_top_i (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .first_port_bits_in(lvl[0]), .first_port_bits_out(out_w[0]), .first_port_bits_oe(oe_w[0]),
    .second_port_bits_in(lvl[1]), .second_port_bits_out(out_w[1]),
    .second_port_bits_oe(oe_w[1]), .third_port_bits_in(lvl[2]),
    .third_port_bits_out(out_w[2]), .third_port_bits_oe(oe_w[2]), .ctr0_out_in(ctr0_out_in),
    .ctr0_gate(ctr0_gate), .ctr1_gate(ctr1_gate), .ctr1_clk(ctr1_clk),
    .converter_wide_mode(conv_wide), .converter_simultaneous_update(conv_sim),
    .counter_pin_select(ctr_sel));

  dpio_pin_model dpio_pin_model_i (.first_drv({out_w[0], oe_w[0]}),
    .second_drv({out_w[1], oe_w[1]}), .third_drv({out_w[2], oe_w[2]}),
    .ext_level(ext_level), .first_lvl(lvl[0]), .second_lvl(lvl[1]), .third_lvl(lvl[2]));

  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // Hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Bus master and expectations
  // ==========================================================
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", hresp, 0);
  endtask : bus

  function automatic logic [7:0] oe_exp(int p, logic [7:0] c);
    if (p == 0) return {8{~c[4]}};
    if (p == 1) return {8{~c[1]}};
    return c[7] ? {4'h8, {4{~c[0]}}} : {{4{~c[3]}}, {4{~c[0]}}};
  endfunction : oe_exp

  // Counter mode puts the counter output on the top bit of the third port
  function automatic logic [7:0] drv_exp(int p, logic [7:0] c, logic [7:0] d, logic ctr);
    if (p == 2 && c[7]) d[7] = ctr;
    return d & oe_exp(p, c);
  endfunction : drv_exp

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [31:0] rd;
    logic [7:0] cfg;
    logic [7:0] dat [3];
    logic [7:0] o;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 3; p++) check("oe after reset", oe_w[p], 0);
      bus(0, 12'h02c, 8'h00, rd);
      check("cfg after reset", rd, 32'h1b);
      check("ctr after reset", {ctr0_gate, ctr1_gate, ctr1_clk, ctr_sel, conv_wide, conv_sim},
        0);
      if (k == 1) break;
      for (int i = 0; i < 48; i++) begin
        cfg = 8'($random(seed));
        // Counter mode kept while the upper direction bit flips, then counter mode off
        if (i < 5) cfg = (i == 0) ? 8'h00 : (i == 1) ? 8'h88 : (i == 2) ? 8'hff :
          (i == 3) ? 8'hf7 : 8'h7b;
        for (int p = 0; p < 3; p++) dat[p] = 8'($random(seed));
        ext_level <= 24'($random(seed));
        ctr0_out_in <= 1'($random(seed));
        bus(1, 12'h02c, cfg, rd);
        for (int p = 0; p < 3; p++) bus(1, 12'h020 + 12'(4 * p), dat[p], rd);
        repeat (3) @(posedge clk_sys);
        bus(0, 12'h02c, 8'h00, rd);
        check("cfg readback", rd, {24'h0, cfg & 8'hfb});
        check("cfg outputs", {conv_wide, conv_sim, ctr_sel}, {cfg[6:5], cfg[7]});
        check("ctr pins", {ctr1_clk, ctr1_gate, ctr0_gate}, cfg[7] ? ext_level[22:20] : 0);
        for (int p = 0; p < 3; p++) begin
          o = oe_exp(p, cfg);
          check("port oe", oe_w[p], o);
          check("port out", out_w[p] & o, drv_exp(p, cfg, dat[p], ctr0_out_in));
          bus(0, 12'h020 + 12'(4 * p), 8'h00, rd);
          check("port read", rd, drv_exp(p, cfg, dat[p], ctr0_out_in)
            | (ext_level[8*p +: 8] & ~o));
        end
        bus(1, 12'h030, 8'hff, rd);
        bus(0, (i % 2) ? 12'h030 : 12'h02d, 8'h00, rd);
        check("unmapped read", rd, 0);
      end
      bus(0, 12'h02c, 8'h00, rd);
      check("cfg after unmapped write", rd, {24'h0, cfg & 8'hfb});
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
    end
    print_verdict();
  end
endmodule : tb_top
